//--- hw/adc_port_pkg.sv
package adc_port_pkg;

  // Result word
  localparam int          ResultWidth   = 12;
  localparam logic [11:0] ResultReset   = 12'h000;
  localparam logic [11:0] CodePosFull   = 12'h7FF;
  localparam logic [11:0] CodeMid       = 12'h000;
  localparam logic [11:0] CodeNegFull   = 12'h800;

  // Clock and timing figures
  localparam int ClockPeriodNs  = 10;
  localparam int BusyDelayNs    = 65;    // Longest busy fall delay
  localparam int ConvTimeNs     = 8000;  // Longest busy low time
  localparam int ResultSetupNs  = 50;    // Least data valid before busy rise
  localparam int PrevValidNs    = 16000; // Previous result kept after start

  // Cycle counts: longest times round down, least times round up
  localparam int BusyDelayCycles  = (BusyDelayNs / ClockPeriodNs) < 1 ? 1 :
                                    BusyDelayNs / ClockPeriodNs;
  localparam int ConvCycles       = ConvTimeNs / ClockPeriodNs;
  localparam int ResultSetupCycles = (ResultSetupNs + ClockPeriodNs - 1) / ClockPeriodNs;
  localparam int PrevValidCycles  = PrevValidNs / ClockPeriodNs;

  localparam int CountWidth = 11;

  typedef enum logic [1:0] {
    Idle,
    Converting,
    Settling
  } conv_state_e;

endpackage

//--- hw/sar_adc_convert_read_port.sv
`timescale 1ns/1ns
// Behaviour
// - Previous result stays readable until the new one reaches the bus, just under 8 us after a conversion starts.
// - With chip select tied low, convert/read line alone converts and reads.
// - New result is on the bus within 8 us of the convert edge.
// - Busy rises at least 50 ns after the new result is valid.
// - Busy falls within 65 ns of convert, stays low at most 8 us.
// - Convert commands are ignored while busy is low.
// - Bus driven only with convert/read high and chip select low.
// - Results are 12-bit two's complement, 7FF to 800.
module sar_adc_convert_read_port
#(
  parameter int ConvCyclesP = adc_port_pkg::ConvCycles
)(
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                reset,
  // Host control pins
  input  wire logic                                readNotConvert,
  input  wire logic                                chipSelectN,
  // Sample from the converter core, two's complement
  input  wire logic [adc_port_pkg::ResultWidth-1:0] sampleCode,
  // Status and data bus
  output logic                                     busyN,
  output logic [adc_port_pkg::ResultWidth-1:0]     dataOut,
  output logic                                     dataOutEnableN
);
  import adc_port_pkg::*;

  // Timing budget, counted from the edge at which busy falls (E):
  //   E + 1 .. E + T + 1  converting, T = ConvCyclesP - setup - 2
  //   E + T + 1           internal result register loads
  //   E + T + 2           result reaches the output register
  //   E + ConvCyclesP     busy returns high, setup cycles later
  // So busy is low for exactly ConvCyclesP cycles and the word on
  // the bus is settled for the full setup margin before busy rises.
  // The margin is counted from the output register, not from the
  // internal one, because the host sees only the output register.
  //
  // Pin to busy latency is three synchroniser stages plus the
  // agree stage plus one register, about five cycles in all.
  // That stays inside the 65 ns budget at a 10 ns clock; a slower
  // clock would break it, which is a limitation of this scheme.

  // Pin synchronisers, three stages each
  logic [2:0] rncSync_q;
  logic [2:0] rncSync_d;
  logic [2:0] csSync_q;
  logic [2:0] csSync_d;
  logic       rncStable_q;
  logic       rncStable_d;
  logic       csStable_q;
  logic       csStable_d;

  // Conversion state
  conv_state_e           state_q;
  conv_state_e           state_d;
  logic [CountWidth-1:0] count_q;
  logic [CountWidth-1:0] count_d;
  logic [ResultWidth-1:0] result_q;
  logic [ResultWidth-1:0] result_d;
  logic [ResultWidth-1:0] sampleHold_q;
  logic [ResultWidth-1:0] sampleHold_d;
  logic                  busyN_q;
  logic                  busyN_d;
  logic                  armed_q;
  logic                  armed_d;

  // Bus output state
  logic [ResultWidth-1:0] dataOut_q;
  logic [ResultWidth-1:0] dataOut_d;
  logic                  oeN_q;
  logic                  oeN_d;

  logic convertCmd;

  // Change counts only when second and third stages agree.
  // The agree stage filters a single-cycle glitch on a pin, which
  // costs one cycle of latency but keeps a runt pulse from
  // starting a conversion that the host never asked for.
  always_comb
  begin
    rncSync_d   = {rncSync_q[1:0], readNotConvert};
    csSync_d    = {csSync_q[1:0], chipSelectN};
    rncStable_d = (rncSync_q[2] == rncSync_q[1]) ? rncSync_q[2] : rncStable_q;
    csStable_d  = (csSync_q[2] == csSync_q[1]) ? csSync_q[2] : csStable_q;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rncSync_q   <= 3'h7;
      csSync_q    <= 3'h7;
      rncStable_q <= 1'b1;
      csStable_q  <= 1'b1;
    end
    else
    begin
      rncSync_q   <= rncSync_d;
      csSync_q    <= csSync_d;
      rncStable_q <= rncStable_d;
      csStable_q  <= csStable_d;
    end
  end

  // Inputs are OR'd and level triggered; chip select tied low works too
  assign convertCmd = ~rncStable_q & ~csStable_q;

  // Conversion sequencer
  // Level triggered, so a held command re-arms only after release,
  // which stops a long convert pulse starting back-to-back conversions.
  always_comb
  begin
    state_d      = state_q;
    count_d      = count_q;
    result_d     = result_q;
    sampleHold_d = sampleHold_q;
    busyN_d      = busyN_q;
    armed_d      = armed_q | ~convertCmd;
    unique case (state_q)
      Idle:
      begin
        if (convertCmd && armed_q)
        begin
          // Busy falls the cycle after the command is seen
          busyN_d      = 1'b0;
          sampleHold_d = sampleCode; // Hold the sample at the start
          armed_d      = 1'b0;
          count_d      = '0;
          state_d      = Converting;
        end
      end
      Converting:
      begin
        // Commands during busy low are ignored
        armed_d = 1'b0;
        count_d = count_q + 1'b1;
        if (count_q == CountWidth'(ConvCyclesP - ResultSetupCycles - 2))
        begin
          // Result kept as two's complement word
          result_d = sampleHold_q;
          count_d  = '0;
          state_d  = Settling;
        end
      end
      Settling:
      begin
        armed_d = 1'b0;
        count_d = count_q + 1'b1;
        // Counts 0 .. setup, so the output register holds the new
        // word for the whole setup margin before busy rises
        if (count_q == CountWidth'(ResultSetupCycles))
        begin
          // Busy rises only after the data setup margin
          busyN_d = 1'b1;
          state_d = Idle;
        end
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q      <= Idle;
      count_q      <= '0;
      result_q     <= ResultReset;
      sampleHold_q <= ResultReset;
      busyN_q      <= 1'b1;
      armed_q      <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      count_q      <= count_d;
      result_q     <= result_d;
      sampleHold_q <= sampleHold_d;
      busyN_q      <= busyN_d;
      armed_q      <= armed_d;
    end
  end

  // Output bus: previous result stays on the bus until the new
  // word reaches it at E + T + 2, well inside the 16 us window
  // The bus word is registered even while the enable is off, so a
  // read that begins mid conversion sees a settled word at once.
  // The enable follows the synchronised pins, so it lags the pins
  // by the same few cycles as the convert path does.
  always_comb
  begin
    oeN_d     = ~(rncStable_q & ~csStable_q);
    dataOut_d = result_q;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      oeN_q     <= 1'b1;
      dataOut_q <= ResultReset;
    end
    else
    begin
      oeN_q     <= oeN_d;
      dataOut_q <= dataOut_d;
    end
  end

  assign busyN          = busyN_q;
  assign dataOut        = dataOut_q;
  assign dataOutEnableN = oeN_q;

endmodule

//--- verification/adc_port_properties.sv
`timescale 1ns/1ns
module adc_port_checker
  import adc_port_pkg::*;
#(
  parameter int ConvCyclesP = 20
)(
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   reset,
  // Host pins and sample
  input wire logic                   readNotConvert,
  input wire logic                   chipSelectN,
  input wire logic [ResultWidth-1:0] sampleCode,
  // Status and bus
  input wire logic                   busyN,
  input wire logic [ResultWidth-1:0] dataOut,
  input wire logic                   dataOutEnableN
);
  int lowCnt_q;
  // Busy low length; a sticky busy would hide in a bare delay check
  always_ff @(posedge clock)
    lowCnt_q <= (reset || busyN) ? 0 : lowCnt_q + 1;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  bus_on_a: assert property ((readNotConvert && !chipSelectN)[*6] |-> !dataOutEnableN)
    else $error("bus not driven");
  bus_off_a: assert property ((!readNotConvert || chipSelectN)[*6] |-> dataOutEnableN)
    else $error("bus driven");
  busy_fall_a: assert property ($fell(busyN) |-> $past(!readNotConvert, 3))
    else $error("busy fell without command");
  busy_max_a: assert property (!busyN |-> lowCnt_q < ConvCyclesP)
    else $error("busy low too long");
  busy_len_a: assert property ($rose(busyN) |-> lowCnt_q == ConvCyclesP)
    else $error("busy length wrong");
  result_setup_a: assert property ($changed(dataOut) |-> !busyN[*5])
    else $error("result too close to busy rise");
  prev_data_a: assert property ($fell(busyN) |-> $stable(dataOut)[*8])
    else $error("previous result lost early");
  no_refire_a: assert property ($rose(busyN) |=> busyN[*3])
    else $error("held command restarted");
  cover property ($rose(busyN));
  cover property (!dataOutEnableN && !busyN);
  cover property (!busyN && !readNotConvert);
endmodule
bind sar_adc_convert_read_port adc_port_checker #(.ConvCyclesP(ConvCyclesP)) chk (
  .clock(clock), .reset(reset), .readNotConvert(readNotConvert),
  .chipSelectN(chipSelectN), .sampleCode(sampleCode), .busyN(busyN),
  .dataOut(dataOut), .dataOutEnableN(dataOutEnableN));

//--- verification/host_model.sv
`timescale 1ns/1ns
module host_model (
  // Clock
  input wire logic        clock,
  // Pins toward the converter
  output logic            rc,
  output logic            cs,
  // Status and data back
  input wire logic        busyN,
  input wire logic [11:0] dataOut,
  output logic [11:0]     latched
);
  logic busyQ = 1'b1;
  // Chip select starts low, convert line alone steers
  initial {rc, cs} = 2'b10;
  task automatic pins(input logic r, input logic c);
    @(posedge clock);
    #1 {rc, cs} = {r, c};
  endtask
  // Pulse stays between 40 ns and 6 us
  task automatic convert(input int n);
    pins(1'b0, 1'b0);
    repeat (n) @(posedge clock);
    #1 rc = 1'b1;
  endtask
  // Latch on busy rise, never mid conversion
  always @(posedge clock)
  begin
    busyQ <= busyN;
    if (busyN && !busyQ) latched <= dataOut;
  end
endmodule

//--- verification/sar_adc_convert_read_port_bench.sv
`timescale 1ns/1ns
module sar_adc_convert_read_port_bench;
  import adc_port_pkg::*;
  logic        clock = 0;
  logic        reset = 1;
  logic [11:0] sampleCode = 12'h000;
  logic        rc, cs, busyN, en;
  logic [11:0] dataOut, latched;
  int          bad_count = 0;
  int          num_checks = 0;
  logic [11:0] rows [4][2] = '{'{CodePosFull, 12'h7FF}, '{CodeMid, 12'h000},
                               '{12'hFFF, 12'hFFF}, '{CodeNegFull, 12'h800}};
  always #5 clock = ~clock;
  sar_adc_convert_read_port #(.ConvCyclesP(20)) DUT (.clock(clock), .reset(reset),
    .readNotConvert(rc), .chipSelectN(cs), .sampleCode(sampleCode), .busyN(busyN),
    .dataOut(dataOut), .dataOutEnableN(en));
  host_model host (.clock(clock), .rc(rc), .cs(cs), .busyN(busyN), .dataOut(dataOut),
    .latched(latched));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for busy low then high
  task automatic settle();
    int n;
    for (n = 0; n < 60 && busyN !== 1'b0; n++) @(posedge clock);
    for (n = 0; n < 60 && busyN !== 1'b1; n++) @(posedge clock);
    repeat (6) @(posedge clock);
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clock);
    #1 reset = 0;
    check({9'h0, busyN, en, dataOut[0]}, 12'h006);
    foreach (rows[i])
    begin
      sampleCode = rows[i][0];
      host.convert(8);
      settle();
      check(latched, rows[i][1]);
      check({dataOut[11:1], en}, {rows[i][1][11:1], 1'b0});
    end
    host.pins(1'b1, 1'b1);
    repeat (6) @(posedge clock);
    check({11'h0, en}, 12'h001);
    host.pins(1'b1, 1'b0);
    sampleCode = 12'h123;
    host.convert(8);
    repeat (6) @(posedge clock);
    check({dataOut[11:1], en}, 12'h800);
    settle();
    check(latched, 12'h123);
    // Command held low across busy rise must not restart
    sampleCode = 12'h456;
    host.pins(1'b0, 1'b0);
    settle();
    repeat (10) @(posedge clock);
    check({busyN, latched[10:0]}, 12'hC56);
    host.pins(1'b1, 1'b0);
    host.convert(8);
    reset = 1;
    repeat (2) @(posedge clock);
    #1 reset = 0;
    check({busyN, dataOut[10:0]}, 12'h800);
    test_done();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #50000 bad_count++;
    test_done();
  end
endmodule
